// ---- core/cic_core_irq.sv ----
// Interrupt enable and flag registers of the core, with an AXI4-Lite slave.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module cic_core_irq
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [cic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cic_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [cic_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cic_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [cic_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_irq_pin,
  input wire logic [cic_pkg::PIN_W-1:0] upper_port_pins,
  input wire logic timer0_overflow,
  input wire logic [cic_pkg::PER_W-1:0] periph_events,
  input wire logic [cic_pkg::PER_W-1:0] periph_enables,
  input wire logic irq_taken,
  output logic core_irq_request,
  output logic [cic_pkg::VEC_W-1:0] vector_addr,
  output logic vector_load,
  output logic irq
);
  import cic_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic have_aw;
    logic have_w;
    logic [IDX_W-1:0] aw_idx;
    logic [REG_W-1:0] wbyte;
    logic wen;
    logic [REG_W-1:0] interrupt_control;
    logic [REG_W-1:0] pir;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic core_req;
    logic irq;
  } cic_state_t;

  cic_state_t st;
  cic_state_t next_st;

  cic_link_if link ();

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic is_interrupt_control(input logic [IDX_W-1:0] idx);
    is_interrupt_control = (idx == IDX_INTERRUPT_CONTROL_B0) || (idx == IDX_INTERRUPT_CONTROL_B1);
  endfunction : is_interrupt_control

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = is_interrupt_control(idx) || (idx == IDX_PIR) || (idx == IDX_STATUS) || (idx == IDX_MASK);
  endfunction : is_mapped

  // Places the four peripheral lines at their flag positions.
  function automatic logic [REG_W-1:0] place_periph(input logic [PER_W-1:0] v);
    place_periph = '0;
    place_periph[T1_BIT] = v[0];
    place_periph[T2_BIT] = v[1];
    place_periph[CC_BIT] = v[2];
    place_periph[CONV_BIT] = v[3];
  endfunction : place_periph

  function automatic logic [REG_W-1:0] read_value(input logic [IDX_W-1:0] idx, input cic_state_t s);
    read_value = '0;
    if (is_interrupt_control(idx))
    begin
      read_value = s.interrupt_control;
    end
    else if (idx == IDX_PIR)
    begin
      read_value = s.pir;
    end
    else if (idx == IDX_STATUS)
    begin
      read_value = {1'b0, s.status};
    end
    else if (idx == IDX_MASK)
    begin
      read_value = {1'b0, s.mask};
    end
  endfunction : read_value

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic do_write;
  logic rd_status;
  logic [EVT_W-1:0] events;
  logic periph_req;
  logic [IDX_W-1:0] ar_idx;

  assign ar_idx = s_axi_araddr[ADDR_W-1:2];

  always_comb
  begin
    next_st = st;
    do_write = 1'b0;
    rd_status = 1'b0;

    // Write address and data are taken independently, in either order.
    if (st.awready && s_axi_awvalid)
    begin
      next_st.awready = 1'b0;
      next_st.have_aw = 1'b1;
      next_st.aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (st.wready && s_axi_wvalid)
    begin
      next_st.wready = 1'b0;
      next_st.have_w = 1'b1;
      next_st.wbyte = s_axi_wdata[REG_W-1:0];
      next_st.wen = s_axi_wstrb[0];
    end
    if (st.have_aw && st.have_w && !st.bvalid)
    begin
      next_st.have_aw = 1'b0;
      next_st.have_w = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(st.aw_idx) ? RESP_OKAY : RESP_SLVERR;
      do_write = st.wen;
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end

    // A read of the status word hands back its bits and clears them.
    if (st.arready && s_axi_arvalid)
    begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = {{(DATA_W-REG_W){1'b0}}, read_value(ar_idx, st)};
      next_st.rresp = is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      rd_status = (ar_idx == IDX_STATUS);
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // Software writes land first; a hardware event in the same cycle wins.
    if (do_write && is_interrupt_control(st.aw_idx))
    begin
      next_st.interrupt_control = st.wbyte;
    end
    if (do_write && (st.aw_idx == IDX_PIR))
    begin
      next_st.pir = st.wbyte;
    end
    if (do_write && (st.aw_idx == IDX_MASK))
    begin
      next_st.mask = st.wbyte[EVT_W-1:0];
    end
    next_st.interrupt_control[OVF_FLAG_BIT] = next_st.interrupt_control[OVF_FLAG_BIT] | timer0_overflow;
    next_st.interrupt_control[EXT_FLAG_BIT] = next_st.interrupt_control[EXT_FLAG_BIT] | link.ext_event;
    next_st.interrupt_control[PORT_FLAG_BIT] = next_st.interrupt_control[PORT_FLAG_BIT] | link.port_event;
    next_st.pir = (next_st.pir | place_periph(periph_events)) & PIR_IMPL;

    events = '0;
    events[ST_OVF] = timer0_overflow;
    events[ST_EXT] = link.ext_event;
    events[ST_PORT] = link.port_event;
    events[ST_PER +: PER_W] = periph_events;
    next_st.status = (rd_status ? STATUS_RST : st.status) | events;
    next_st.irq = |(next_st.status & next_st.mask);

    // Peripheral flags pass their own enables and then the group enable.
    periph_req = next_st.interrupt_control[PERIPH_EN_BIT]
      && |(next_st.pir & place_periph(periph_enables));
    next_st.core_req = next_st.interrupt_control[GLOBAL_EN_BIT]
      && ((next_st.interrupt_control[OVF_EN_BIT] && next_st.interrupt_control[OVF_FLAG_BIT])
      || (next_st.interrupt_control[EXT_EN_BIT] && next_st.interrupt_control[EXT_FLAG_BIT])
      || (next_st.interrupt_control[PORT_EN_BIT] && next_st.interrupt_control[PORT_FLAG_BIT])
      || periph_req);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // The enables leave reset cleared so that stale flags cannot raise a
  // request before software has tidied them up.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.interrupt_control <= INTERRUPT_CONTROL_RST;
      st.pir <= PIR_RST;
      st.status <= STATUS_RST;
      st.mask <= MASK_RST;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Submodules
  // ****************************************************************
  cic_pin_sync u_pin_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .external_irq_pin(external_irq_pin),
    .upper_port_pins(upper_port_pins),
    .link(link.src)
  );

  cic_vector u_vector
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .irq_taken(irq_taken),
    .link(link.vec),
    .vector_addr(vector_addr),
    .vector_load(vector_load)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.core_request = st.core_req;
  assign core_irq_request = st.core_req;
  assign irq = st.irq;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;

endmodule : cic_core_irq

// ---- core/cic_pin_sync.sv ----
// Pin synchroniser and event detector for the external and port change sources.
`timescale 1ns/100ps
module cic_pin_sync
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic external_irq_pin,
  input wire logic [cic_pkg::PIN_W-1:0] upper_port_pins,
  cic_link_if.src link
);
  import cic_pkg::*;

  typedef struct packed {
    logic [1:0] warm;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic [PIN_W-1:0] port_s1;
    logic [PIN_W-1:0] port_s2;
    logic [PIN_W-1:0] port_prev;
    logic ext_event;
    logic port_event;
  } cic_sync_state_t;

  cic_sync_state_t st;
  cic_sync_state_t next_st;

  // Events are held off until the sampling chain is filled, so pins that
  // sit high at reset release do not report a false change.
  always_comb
  begin
    next_st = st;
    next_st.ext_s1 = external_irq_pin;
    next_st.ext_s2 = st.ext_s1;
    next_st.ext_prev = st.ext_s2;
    next_st.port_s1 = upper_port_pins;
    next_st.port_s2 = st.port_s1;
    next_st.port_prev = st.port_s2;
    if (st.warm != WARM_DONE)
    begin
      next_st.warm = st.warm + 2'h1;
    end
    next_st.ext_event = (st.warm == WARM_DONE) && st.ext_s2 && !st.ext_prev;
    next_st.port_event = (st.warm == WARM_DONE) && (st.port_s2 != st.port_prev);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  assign link.ext_event = st.ext_event;
  assign link.port_event = st.port_event;

endmodule : cic_pin_sync

// ---- core/cic_vector.sv ----
// Program address redirection for reset and for a taken interrupt.
`timescale 1ns/100ps
module cic_vector
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic irq_taken,
  cic_link_if.vec link,
  output logic [cic_pkg::VEC_W-1:0] vector_addr,
  output logic vector_load
);
  import cic_pkg::*;

  typedef struct packed {
    logic [VEC_W-1:0] addr;
    logic load;
  } cic_vec_state_t;

  cic_vec_state_t st;
  cic_vec_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.load = irq_taken && link.core_request;
    if (irq_taken && link.core_request)
    begin
      next_st.addr = IRQ_VECTOR;
    end
  end

  // Reset itself presents the start address with a load strobe.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '{addr: RESET_VECTOR, load: 1'b1};
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  assign vector_addr = st.addr;
  assign vector_load = st.load;

endmodule : cic_vector

// ---- dv/cic_core_irq_chk.sv ----
// Assertion checker bound to the core interrupt control block.
`timescale 1ns/100ps
module cic_core_irq_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [cic_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_irq_pin,
  input wire logic [cic_pkg::PIN_W-1:0] upper_port_pins,
  input wire logic timer0_overflow,
  input wire logic [cic_pkg::PER_W-1:0] periph_events,
  input wire logic [cic_pkg::PER_W-1:0] periph_enables,
  input wire logic irq_taken,
  input wire logic core_irq_request,
  input wire logic [cic_pkg::VEC_W-1:0] vector_addr,
  input wire logic vector_load
);
  import cic_pkg::*;
  logic [4:0] pins_q;
  logic [3:0] pin_age;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Pin events reach the flags a few edges late, so a recent pin change counts as a cause.
  always_ff @(posedge aclk)
  begin
    pins_q <= {external_irq_pin, upper_port_pins};
    if (!aresetn || pins_q != {external_irq_pin, upper_port_pins})
      pin_age <= 4'h0;
    else if (pin_age != 4'hf)
      pin_age <= pin_age + 4'h1;
  end
  a_req_cause: assert property ($rose(core_irq_request) |-> $rose(s_axi_bvalid) || $past(timer0_overflow)
    || $past(periph_events) != 4'h0 || $past(periph_enables) != $past(periph_enables, 2) || pin_age < 4'h8)
    else $error("request rose without a cause");
  a_take_vec: assert property (clk_en && irq_taken && core_irq_request
    |=> vector_load && vector_addr == IRQ_VECTOR) else $error("taken interrupt missed the vector");
  a_reset_vec: assert property ($rose(aresetn) |-> vector_load && vector_addr == RESET_VECTOR)
    else $error("reset vector not loaded");
  a_vec_pulse: assert property ($rose(vector_load) && clk_en |=> !vector_load)
    else $error("vector load longer than one cycle");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_b_drop: assert property (clk_en && s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write response not closed");
  a_rd_answer: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_r_drop: assert property (clk_en && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read response not closed");
  a_rdata_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data not zero");
endmodule : cic_core_irq_chk
bind cic_core_irq cic_core_irq_chk u_cic_core_irq_chk (.aclk, .aresetn, .clk_en, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .external_irq_pin, .upper_port_pins, .timer0_overflow, .periph_events, .periph_enables, .irq_taken,
  .core_irq_request, .vector_addr, .vector_load);

// ---- dv/cic_core_irq_tb.sv ----
// Self-checking testbench for the core interrupt control block.
`timescale 1ns/100ps
module cic_core_irq_tb;
  import cic_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, external_irq_pin = 1'b0, timer0_overflow = 1'b0;
  // Response readies stay high, so back-to-back calls never lower and raise one in the same step.
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [STRB_W-1:0] s_axi_wstrb = 4'hf;
  logic [PIN_W-1:0] upper_port_pins = 4'h0;
  logic [PER_W-1:0] periph_events = 4'h0, periph_enables = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq_taken, core_irq_request, vector_load, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [VEC_W-1:0] vector_addr, pc;
  logic [3:0] take_delay = 4'h0;
  int takes, errors = 0, checked = 0;
  always #2.5 aclk = ~aclk;
  cic_core_irq u_cic_core_irq (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_irq_pin,
    .upper_port_pins, .timer0_overflow, .periph_events, .periph_enables, .irq_taken, .core_irq_request,
    .vector_addr, .vector_load, .irq);
  cic_core_model u_cic_core_model (.aclk, .aresetn, .core_irq_request, .vector_addr, .vector_load, .take_delay,
    .irq_taken, .pc, .takes);
  // ****
  // Bus and event tasks
  // ****
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] s);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [IDX_W-1:0] ix, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    while (!s_axi_bvalid && n < 40);
    chk("bresp", {1'b1, er}, {s_axi_bvalid, s_axi_bresp});
  endtask : wr
  task automatic rd(input logic [IDX_W-1:0] ix, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    while (!s_axi_rvalid && n < 40);
    chk("rdata", {1'b1, er, 24'h0, e}, {s_axi_rvalid, s_axi_rresp, s_axi_rdata});
  endtask : rd
  // Pin events pass a synchroniser, so each source gets time to land.
  task automatic fire(input int i);
    @(posedge aclk);
    case (i)
      0: timer0_overflow <= 1'b1;
      1: external_irq_pin <= 1'b1;
      default: upper_port_pins <= ~upper_port_pins;
    endcase
    @(posedge aclk);
    timer0_overflow <= 1'b0;
    cyc(8);
    external_irq_pin <= 1'b0;
    cyc(8);
  endtask : fire
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    rd(IDX_INTERRUPT_CONTROL_B0, INTERRUPT_CONTROL_RST);
    rd(IDX_PIR, PIR_RST);
    rd(IDX_STATUS, 8'h00);
    rd(IDX_MASK, 8'h00);
    chk("pc", RESET_VECTOR, pc);
    $display("reset test done");
  endtask : t_reset
  task automatic t_regs();
    wr(IDX_INTERRUPT_CONTROL_B0, 8'h5a);
    rd(IDX_INTERRUPT_CONTROL_B1, 8'h5a);
    wr(IDX_INTERRUPT_CONTROL_B1, 8'h25);
    rd(IDX_INTERRUPT_CONTROL_B0, 8'h25);
    chk("request", 1'b0, core_irq_request);
    s_axi_wstrb <= 4'h0;
    wr(IDX_INTERRUPT_CONTROL_B0, 8'hff);
    s_axi_wstrb <= 4'hf;
    rd(IDX_INTERRUPT_CONTROL_B0, 8'h25);
    wr(IDX_INTERRUPT_CONTROL_B0, 8'h00);
    wr(10'h3f0, 8'h11, RESP_SLVERR);
    rd(10'h3f0, 8'h00, RESP_SLVERR);
    $display("register test done");
  endtask : t_regs
  task automatic t_sticky();
    for (int i = 0; i < 3; i++)
    begin
      fire(i);
      rd(IDX_INTERRUPT_CONTROL_B0, 8'h07 & ~(8'h03 >> i));
    end
    rd(IDX_STATUS, 8'h07);
    rd(IDX_STATUS, 8'h00);
    rd(IDX_INTERRUPT_CONTROL_B0, 8'h07);
    chk("request", 1'b0, core_irq_request);
    wr(IDX_INTERRUPT_CONTROL_B0, 8'h00);
    rd(IDX_INTERRUPT_CONTROL_B0, 8'h00);
    $display("sticky test done");
  endtask : t_sticky
  task automatic t_enables();
    for (int i = 0; i < 3; i++)
    begin
      take_delay <= 4'(i * 5);
      wr(IDX_INTERRUPT_CONTROL_B0, 8'h20 >> i);
      fire(i);
      chk("gated", 1'b0, core_irq_request);
      wr(IDX_INTERRUPT_CONTROL_B0, 8'h80 | (8'h24 >> i));
      chk("request", 1'b1, core_irq_request);
      cyc(16);
      chk("takes", 40'(i + 1), 40'(takes));
      chk("pc", IRQ_VECTOR, pc);
      wr(IDX_INTERRUPT_CONTROL_B0, 8'h80 | (8'h04 >> i));
      chk("disabled", 1'b0, core_irq_request);
      wr(IDX_INTERRUPT_CONTROL_B0, 8'h00);
    end
    $display("enable test done");
  endtask : t_enables
  task automatic t_periph();
    periph_enables <= 4'hf;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge aclk);
      periph_events <= 4'h1 << k;
      @(posedge aclk);
      periph_events <= 4'h0;
    end
    rd(IDX_PIR, 8'h47);
    wr(IDX_INTERRUPT_CONTROL_B0, 8'h80);
    chk("group off", 1'b0, core_irq_request);
    wr(IDX_INTERRUPT_CONTROL_B0, 8'hc0);
    chk("group on", 1'b1, core_irq_request);
    periph_enables <= 4'h0;
    cyc(2);
    chk("own off", 1'b0, core_irq_request);
    wr(IDX_INTERRUPT_CONTROL_B0, 8'h00);
    wr(IDX_PIR, 8'h00);
    rd(IDX_PIR, 8'h00);
    $display("peripheral test done");
  endtask : t_periph
  task automatic t_irq();
    rd(IDX_STATUS, 8'h7f);
    wr(IDX_MASK, 8'h01);
    rd(IDX_MASK, 8'h01);
    chk("irq idle", 1'b0, irq);
    fire(0);
    chk("irq", 1'b1, irq);
    rd(IDX_STATUS, 8'h01);
    chk("irq cleared", 1'b0, irq);
    fire(1);
    chk("irq masked", 1'b0, irq);
    rd(IDX_STATUS, 8'h02);
    clk_en <= 1'b0;
    fire(0);
    clk_en <= 1'b1;
    rd(IDX_STATUS, 8'h00);
    wr(IDX_MASK, 8'h00);
    $display("irq test done");
  endtask : t_irq
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  initial
  begin
    cyc(10);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    t_sticky();
    t_enables();
    t_periph();
    t_irq();
    stop_test();
  end
  initial
  begin
    cyc(20000);
    errors++;
    stop_test();
  end
endmodule : cic_core_irq_tb

// ---- dv/cic_core_model.sv ----
// Behavioural model of the processor core that takes interrupts and fetches vectors.
`timescale 1ns/100ps
module cic_core_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic core_irq_request,
  input wire logic [cic_pkg::VEC_W-1:0] vector_addr,
  input wire logic vector_load,
  input wire logic [3:0] take_delay,
  output logic irq_taken,
  output logic [cic_pkg::VEC_W-1:0] pc,
  output int takes
);
  import cic_pkg::*;
  logic armed;
  logic [3:0] wait_cnt;
  // Each request is taken once; the core stays away until it has dropped.
  always_ff @(posedge aclk)
  begin
    irq_taken <= 1'b0;
    if (vector_load)
      pc <= vector_addr;
    if (!aresetn || !core_irq_request)
    begin
      armed <= 1'b1;
      wait_cnt <= 4'h0;
      if (!aresetn)
        takes <= 0;
    end
    else if (armed && wait_cnt == take_delay)
    begin
      irq_taken <= 1'b1;
      armed <= 1'b0;
      takes <= takes + 1;
    end
    else if (armed)
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule : cic_core_model

// ---- inc/cic_link_if.sv ----
// Interface joining the pin synchroniser, the control logic and the vector logic.
`timescale 1ns/100ps
interface cic_link_if;
  logic ext_event;
  logic port_event;
  logic core_request;
  modport src (output ext_event, output port_event);
  modport ctl (input ext_event, input port_event, output core_request);
  modport vec (input core_request);
endinterface : cic_link_if

// ---- inc/cic_pkg.sv ----
// Shared constants for the core interrupt control block.
package cic_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int PIN_W = 4;
  localparam int PER_W = 4;
  localparam int EVT_W = 7;
  localparam int VEC_W = 13;
  localparam int STRB_W = 4;

  // ****************************************************************
  // Register word indices, byte address is four times the index
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_INTERRUPT_CONTROL_B0 = 10'h00b;
  localparam logic [IDX_W-1:0] IDX_INTERRUPT_CONTROL_B1 = 10'h08b;
  localparam logic [IDX_W-1:0] IDX_PIR = 10'h00c;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h020;
  localparam logic [IDX_W-1:0] IDX_MASK = 10'h021;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int OVF_EN_BIT = 5;
  localparam int EXT_EN_BIT = 4;
  localparam int PORT_EN_BIT = 3;
  localparam int OVF_FLAG_BIT = 2;
  localparam int EXT_FLAG_BIT = 1;
  localparam int PORT_FLAG_BIT = 0;
  localparam int CONV_BIT = 6;
  localparam int CC_BIT = 2;
  localparam int T2_BIT = 1;
  localparam int T1_BIT = 0;
  localparam int ST_OVF = 0;
  localparam int ST_EXT = 1;
  localparam int ST_PORT = 2;
  localparam int ST_PER = 3;

  // ****************************************************************
  // Reset values, codes and counts
  // ****************************************************************
  localparam logic [REG_W-1:0] INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic [REG_W-1:0] PIR_RST = 8'h00;
  localparam logic [REG_W-1:0] PIR_IMPL = 8'h47;
  localparam logic [EVT_W-1:0] STATUS_RST = 7'h00;
  localparam logic [EVT_W-1:0] MASK_RST = 7'h00;
  localparam logic [VEC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [VEC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] WARM_DONE = 2'h3;

endpackage : cic_pkg
